// ### common/piso_pkg.sv
// piso_pkg: shared constants for the parallel-in serial-out shifter.
// assumes: included before the shifter module; no other dependencies.
package piso_pkg;
   // --------------------------------------------------------------
   // geometry
   // --------------------------------------------------------------
   localparam int PISO_STAGES = 8;
   localparam int PISO_SYNC_DEPTH = 2;
   // pin positions in the synchroniser word
   localparam int PISO_PIN_LOAD = 0;
   localparam int PISO_PIN_CLKA = 1;
   localparam int PISO_PIN_CLKB = 2;
   localparam int PISO_PIN_SER = 3;
   localparam int PISO_PIN_PAR = 4;
   // synchroniser start levels: load and both clocks high, serial low,
   // so reset release makes no false load and no false clock edge
   localparam logic [3:0] PISO_CTL_IDLE = 4'h7;
   // stage contents after the async reset; all stages cleared to zero
   localparam logic [PISO_STAGES-1:0] PISO_STAGE_RST = 8'h00;
   // --------------------------------------------------------------
   // link states
   // --------------------------------------------------------------
   typedef enum logic [1:0] {PISO_ST_LOAD, PISO_ST_SHIFT} piso_mode_t;
endpackage

// ### logic/piso_shifter.sv
// piso_shifter: eight-stage parallel-in, serial-out shift register.
// assumes: all pin inputs asynchronous to clk; pins sampled through two
// flip-flops, so pin edges reach the stages a few clk cycles late.
`timescale 1ns/1ps
module piso_shifter
   import piso_pkg::*;
#(
   parameter int STAGES = PISO_STAGES
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic load_b,
   input wire logic clk_in_a,
   input wire logic clk_in_b,
   input wire logic serial_in,
   input wire logic [STAGES-1:0] par_in,
   output logic first_stage_out,
   output logic second_stage_out,
   output logic seventh_stage_out,
   output logic last_stage_out,
   output logic last_stage_out_b,
   output logic loaded
);
   // --------------------------------------------------------------
   // pin synchronisers
   // --------------------------------------------------------------
   localparam int NSYNC = STAGES + PISO_PIN_PAR;
   localparam logic [NSYNC-1:0] SYNC_RST = {{STAGES{1'b0}}, PISO_CTL_IDLE};
   logic [NSYNC-1:0] pins;
   logic [NSYNC-1:0] sync1_r;
   logic [NSYNC-1:0] sync2_r;
   assign pins = {par_in, serial_in, clk_in_b, clk_in_a, load_b};
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_r <= SYNC_RST;
         sync2_r <= SYNC_RST;
      end else begin
         sync1_r <= pins;
         sync2_r <= sync1_r;
      end
   end
   logic load_s;
   logic ca_s;
   logic cb_s;
   logic ser_s;
   logic [STAGES-1:0] par_s;
   assign load_s = sync2_r[PISO_PIN_LOAD];
   assign ca_s = sync2_r[PISO_PIN_CLKA];
   assign cb_s = sync2_r[PISO_PIN_CLKB];
   assign ser_s = sync2_r[PISO_PIN_SER];
   assign par_s = sync2_r[NSYNC-1:PISO_PIN_PAR];

   // --------------------------------------------------------------
   // gated shift clock, as a one-cycle enable
   // --------------------------------------------------------------
   logic gclk_s;
   logic gclk_r;
   logic gclk_nxt;
   assign gclk_s = ~(ca_s | cb_s);
   // falling edge of the nor: one clock input rising while the other is
   // low; inhibit raised while the clock is low would make one as well
   logic shift_en;
   assign shift_en = load_s & gclk_r & ~gclk_s;
   assign gclk_nxt = gclk_s;

   // --------------------------------------------------------------
   // stage chain
   // --------------------------------------------------------------
   logic [STAGES-1:0] stage_r;
   logic [STAGES-1:0] stage_nxt;
   logic loaded_r;
   logic loaded_nxt;
   always_comb begin
      stage_nxt = stage_r;
      loaded_nxt = loaded_r;
      if (!load_s) begin
         // transparent load, also covers the falling edge of load
         stage_nxt = par_s;
         loaded_nxt = 1'b1;
      end else if (shift_en) begin
         stage_nxt = {stage_r[STAGES-2:0], ser_s};
      end
      // otherwise hold: par_s unused while load high
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stage_r <= PISO_STAGE_RST;
         gclk_r <= 1'b0;
         loaded_r <= 1'b0;
      end else begin
         stage_r <= stage_nxt;
         gclk_r <= gclk_nxt;
         loaded_r <= loaded_nxt;
      end
   end

   // --------------------------------------------------------------
   // outputs, registered copies of the chain
   // --------------------------------------------------------------
   logic [5:0] out_nxt;
   assign out_nxt = {stage_nxt[0], stage_nxt[1], stage_nxt[STAGES-2],
                     stage_nxt[STAGES-1], ~stage_nxt[STAGES-1], loaded_nxt};
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         first_stage_out <= PISO_STAGE_RST[0];
         second_stage_out <= PISO_STAGE_RST[1];
         seventh_stage_out <= PISO_STAGE_RST[PISO_STAGES-2];
         last_stage_out <= PISO_STAGE_RST[PISO_STAGES-1];
         last_stage_out_b <= ~PISO_STAGE_RST[PISO_STAGES-1];
         loaded <= 1'b0;
      end else begin
         first_stage_out <= out_nxt[5];
         second_stage_out <= out_nxt[4];
         seventh_stage_out <= out_nxt[3];
         last_stage_out <= out_nxt[2];
         last_stage_out_b <= out_nxt[1];
         loaded <= out_nxt[0];
      end
   end

   // --------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------
   property p_load_follow;
      @(posedge clk) disable iff (!rst_b)
      !load_s |=> stage_r == $past(par_s);
   endproperty
   a_load_follow: assert property (p_load_follow)
      else $error("stages not following parallel inputs");

   property p_load_fall;
      @(posedge clk) disable iff (!rst_b)
      $fell(load_s) |=> stage_r == $past(par_s);
   endproperty
   a_load_fall: assert property (p_load_fall)
      else $error("load fall did not copy inputs");

   property p_shift;
      @(posedge clk) disable iff (!rst_b)
      shift_en |=> stage_r == {$past(stage_r[STAGES-2:0]), $past(ser_s)};
   endproperty
   a_shift: assert property (p_shift)
      else $error("shift wrong");

   property p_hold;
      @(posedge clk) disable iff (!rst_b)
      (load_s && ((ca_s || cb_s) == $past(ca_s || cb_s)))
         |=> $stable(stage_r);
   endproperty
   a_hold: assert property (p_hold)
      else $error("stages changed while inhibited");

   property p_ignore_par;
      @(posedge clk) disable iff (!rst_b)
      (load_s && !shift_en) |=> $stable(stage_r);
   endproperty
   a_ignore_par: assert property (p_ignore_par)
      else $error("parallel inputs leaked while load high");

   property p_nor;
      @(posedge clk) disable iff (!rst_b)
      (load_s && $past(!ca_s && !cb_s) && (ca_s || cb_s)) |-> shift_en;
   endproperty
   a_nor: assert property (p_nor)
      else $error("nor clock edge missed");

   property p_swap;
      @(posedge clk) disable iff (!rst_b)
      shift_en |-> (ca_s || cb_s) && $past(!ca_s && !cb_s);
   endproperty
   a_swap: assert property (p_swap)
      else $error("shift without a clock input rising");

   property p_first;
      @(posedge clk) disable iff (!rst_b)
      shift_en |=> first_stage_out == $past(ser_s);
   endproperty
   a_first: assert property (p_first)
      else $error("first stage missed serial input");

   property p_compl;
      @(posedge clk) disable iff (!rst_b)
      last_stage_out != last_stage_out_b
         && last_stage_out == stage_r[STAGES-1];
   endproperty
   a_compl: assert property (p_compl)
      else $error("last stage outputs wrong");

   property p_taps;
      @(posedge clk) disable iff (!rst_b)
      first_stage_out == stage_r[0] && second_stage_out == stage_r[1]
         && seventh_stage_out == stage_r[STAGES-2];
   endproperty
   a_taps: assert property (p_taps)
      else $error("stage outputs do not match the chain");

   property p_loaded;
      @(posedge clk) disable iff (!rst_b)
      !load_s |=> ##1 loaded;
   endproperty
   a_loaded: assert property (p_loaded)
      else $error("loaded flag not set");

   c_load: cover property (@(posedge clk) disable iff (!rst_b) $fell(load_s));
   c_shift: cover property (@(posedge clk) disable iff (!rst_b) shift_en);
   c_inhib: cover property (@(posedge clk) disable iff (!rst_b)
      load_s && ca_s && cb_s);
   c_swap: cover property (@(posedge clk) disable iff (!rst_b)
      shift_en ##1 (load_s && !cb_s && ca_s));
   c_inhib_pulse: cover property (@(posedge clk) disable iff (!rst_b)
      (load_s && ca_s && cb_s) ##1 (load_s && !ca_s && cb_s));
endmodule

// ### tb/piso_ctl_model.sv
// piso_ctl_model: controller model that drives the shifter's pins.
// assumes: tasks are called at a falling clk edge; pins move only then.
`timescale 1ns/1ps
module piso_ctl_model (
   input wire logic clk,
   output logic load_b,
   output logic clk_in_a,
   output logic clk_in_b,
   output logic serial_in,
   output logic [7:0] par_in
);
   // ---------------------------------------------------------
   // pin drive
   // ---------------------------------------------------------
   initial begin
      {load_b, clk_in_a, clk_in_b, serial_in} = 4'h4;
      par_in = 8'h00;
   end
   // four cycles: two sync stages, stage register, margin
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic load(input logic [7:0] p);
      par_in = p;
      load_b = 1'b0;
      step(4);
      load_b = 1'b1;
      step(4);
   endtask
   // raise both first, so the switch never makes a shift edge
   task automatic sel_clock(input logic use_b);
      clk_in_a = 1'b1;
      clk_in_b = 1'b1;
      step(4);
      clk_in_a = !use_b;
      clk_in_b = use_b;
      step(4);
   endtask
   task automatic clock_low(input logic s);
      serial_in = s;
      step(4);
      clk_in_a = 1'b0;
      clk_in_b = 1'b0;
      step(4);
   endtask
   // selected input rises with the other low: this is the shift edge
   task automatic clock_high(input logic use_b);
      clk_in_a = !use_b;
      clk_in_b = use_b;
      step(4);
   endtask
   task automatic set_par(input logic [7:0] p);
      par_in = p;
   endtask
   task automatic set_levels(input logic a, input logic b, input logic s);
      clk_in_a = a;
      clk_in_b = b;
      serial_in = s;
   endtask
   task automatic inhibit();
      clk_in_b = 1'b1;
      step(4);
      clk_in_a = 1'b0;
      step(4);
      clk_in_a = 1'b1;
      step(4);
      clk_in_b = 1'b0;
      step(4);
   endtask
endmodule

// ### tb/test_parallel_in_serial_out_shifter.sv
// test_parallel_in_serial_out_shifter: self-checking bench.
// assumes: piso_ctl_model drives all pins; design runs at 200 MHz.
`timescale 1ns/1ps
module test_parallel_in_serial_out_shifter;
   import piso_pkg::*;
   logic clk;
   logic rst_b;
   logic load_b, clk_in_a, clk_in_b, serial_in;
   logic [7:0] par_in;
   logic first_stage_out, second_stage_out, seventh_stage_out;
   logic last_stage_out, last_stage_out_b, loaded;
   logic [5:0] obs;
   logic [7:0] st;
   int bad_count;
   int n_compared;
   assign obs = {loaded, last_stage_out_b, last_stage_out,
      seventh_stage_out, second_stage_out, first_stage_out};
   // ---------------------------------------------------------
   // structure
   // ---------------------------------------------------------
   piso_shifter piso_shifter_i (.clk(clk), .rst_b(rst_b),
      .load_b(load_b), .clk_in_a(clk_in_a), .clk_in_b(clk_in_b),
      .serial_in(serial_in), .par_in(par_in),
      .first_stage_out(first_stage_out),
      .second_stage_out(second_stage_out),
      .seventh_stage_out(seventh_stage_out),
      .last_stage_out(last_stage_out),
      .last_stage_out_b(last_stage_out_b), .loaded(loaded));
   piso_ctl_model piso_ctl_model_i (.clk(clk), .load_b(load_b),
      .clk_in_a(clk_in_a), .clk_in_b(clk_in_b),
      .serial_in(serial_in), .par_in(par_in));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ---------------------------------------------------------
   // checking
   // ---------------------------------------------------------
   function automatic logic [5:0] want(input logic [7:0] s);
      return {1'b1, ~s[7], s[7], s[6], s[1], s[0]};
   endfunction
   task automatic chk(input logic [5:0] seen, input logic [5:0] exp);
      n_compared = n_compared + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("[ERR] %0t outputs %b, expected %b", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      if (bad_count == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ---------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------
   task automatic t_load(input logic [7:0] p);
      piso_ctl_model_i.load(p);
      st = p;
      chk(obs, want(st));
   endtask
   task automatic t_ignore();
      piso_ctl_model_i.set_par(~st);
      piso_ctl_model_i.step(8);
      chk(obs, want(st));
   endtask
   task automatic t_shift(input logic use_b);
      piso_ctl_model_i.sel_clock(use_b);
      for (int k = 0; k < 8; k++) begin
         piso_ctl_model_i.clock_low(k[0] ^ use_b);
         chk(obs, want(st));
         piso_ctl_model_i.clock_high(use_b);
         st = {st[6:0], k[0] ^ use_b};
         chk(obs, want(st));
      end
   endtask
   task automatic t_inhibit();
      piso_ctl_model_i.inhibit();
      chk(obs, want(st));
   endtask
   // load with both clock pins and the serial pin high
   task automatic t_load_any();
      piso_ctl_model_i.set_levels(1'b1, 1'b1, 1'b1);
      piso_ctl_model_i.load(8'h81);
      chk(obs, want(8'h81));
   endtask
   initial begin
      #200us;
      bad_count = bad_count + 1;
      stop_test();
   end
   initial begin
      rst_b = 1'b0;
      bad_count = 0;
      n_compared = 0;
      repeat (10) @(negedge clk);
      chk(obs, 6'h10);
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      t_load(8'hb4);
      t_load(8'h4b);
      t_ignore();
      t_shift(1'b0);
      t_inhibit();
      t_load(8'h5a);
      t_shift(1'b1);
      t_load_any();
      stop_test();
   end
endmodule
